// ===== rtl/event_counter_pkg.sv
// Constants for the split-mode dual 8-bit event counter
package event_counter_pkg;
  localparam int unsigned CNT_W      = 8;
  localparam logic [7:0]  CNT_RESET  = 8'h00;
  localparam logic [7:0]  CNT_MAX    = 8'hFF;
  localparam int unsigned DIV_W      = 3;
  // Clock-select field encodings
  localparam logic [1:0]  CKSEL_DIV2 = 2'h0;
  localparam logic [1:0]  CKSEL_DIV4 = 2'h1;
  localparam logic [1:0]  CKSEL_DIV8 = 2'h2;
  localparam logic [1:0]  CKSEL_PIN  = 2'h3;
  // Edge-select field encodings
  localparam logic [1:0]  EDGE_FALL  = 2'h0;
  localparam logic [1:0]  EDGE_RISE  = 2'h1;
  localparam logic [1:0]  EDGE_BOTH  = 2'h2;
  localparam logic [1:0]  EDGE_NONE  = 2'h3;
  // Divider tap positions
  localparam int unsigned TAP_DIV2   = 0;
  localparam int unsigned TAP_DIV4   = 1;
  localparam int unsigned TAP_DIV8   = 2;
endpackage

// ===== rtl/dual_8bit_event_counter.sv
// Split-mode dual 8-bit event counter with overflow flags and request
// Behaviour
// RULE_01 - Split select high runs high and low as two independent 8-bit counters.
// RULE_02 - High source: clock div 2, 4, 8, or high pin, by two-bit select.
// RULE_03 - Low source: clock div 2, 4, 8, or low pin, by own two-bit select.
// RULE_04 - Pin edge sensing chosen by per-pin two-bit edge-select field.
// RULE_05 - Counters advance only while the event gate is high.
// RULE_06 - High counter wraps FF to 00, sets high overflow flag, keeps counting.
// RULE_07 - Low counter wraps FF to 00, sets low overflow flag, keeps counting.
// RULE_08 - Any overflow sets the event interrupt request flag.
// RULE_09 - Request flag with enable set raises an interrupt to the processor.
// RULE_10 - Pin edges are synchronised and edge-detected, counted exactly once.
// RULE_11 - Reset clears counters and flags; flags hold until software clears them.
`timescale 1ns/10ps
module dual_8bit_event_counter (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Configuration
  input  wire logic       split_mode_select,
  input  wire logic [1:0] high_clk_sel,
  input  wire logic [1:0] low_clk_sel,
  input  wire logic [1:0] high_edge_sel,
  input  wire logic [1:0] low_edge_sel,
  input  wire logic       event_irq_enable,
  // Event and gate inputs
  input  wire logic       event_pin_high,
  input  wire logic       event_pin_low,
  input  wire logic       event_gate_pin,
  input  wire logic       pwm_event_gate,
  // Flag clears from software
  input  wire logic       clr_high_overflow,
  input  wire logic       clr_low_overflow,
  input  wire logic       clr_irq_request,
  // Status
  output logic      [7:0] event_count_high,
  output logic      [7:0] event_count_low,
  output logic            high_overflow_flag,
  output logic            low_overflow_flag,
  output logic            event_irq_request_flag,
  output logic            event_irq
);

  // ****************************************
  // Prescaler
  // ****************************************
  logic [event_counter_pkg::DIV_W-1:0] div_ff;
  logic [event_counter_pkg::DIV_W-1:0] nxt_div;
  logic [event_counter_pkg::DIV_W-1:0] div_tick;

  assign nxt_div = div_ff + 3'h1;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // One-cycle enables at phi/2, phi/4, phi/8
  genvar t;
  generate
    for (t = 0; t < event_counter_pkg::DIV_W; t++) begin : g_tick
      assign div_tick[t] = (div_ff[t:0] == {(t+1){1'b1}});
    end
  endgenerate

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [1:0] pin_in;
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] prev_ff;
  logic [1:0] pin_edge;
  logic [1:0] edge_sel [2];

  assign pin_in      = {event_pin_high, event_pin_low};
  assign edge_sel[1] = high_edge_sel;
  assign edge_sel[0] = low_edge_sel;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      prev_ff  <= 2'h0;
    end else begin
      sync1_ff <= pin_in;   // RULE_10
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_edge
      always_comb begin
        unique case (edge_sel[p])   // RULE_04
          event_counter_pkg::EDGE_FALL: pin_edge[p] = prev_ff[p] & ~sync2_ff[p];   // RULE_10
          event_counter_pkg::EDGE_RISE: pin_edge[p] = ~prev_ff[p] & sync2_ff[p];
          event_counter_pkg::EDGE_BOTH: pin_edge[p] = prev_ff[p] ^ sync2_ff[p];
          default:                      pin_edge[p] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ****************************************
  // Count source select and gating
  // ****************************************
  logic       gate;
  logic [1:0] clk_sel [2];
  logic [1:0] pulse;

  // Gate enables counting when either gate source is high
  assign gate       = event_gate_pin | pwm_event_gate;
  assign clk_sel[1] = high_clk_sel;
  assign clk_sel[0] = low_clk_sel;

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_src
      logic src;
      always_comb begin
        unique case (clk_sel[s])   // RULE_02 RULE_03
          event_counter_pkg::CKSEL_DIV2: src = div_tick[event_counter_pkg::TAP_DIV2];
          event_counter_pkg::CKSEL_DIV4: src = div_tick[event_counter_pkg::TAP_DIV4];
          event_counter_pkg::CKSEL_DIV8: src = div_tick[event_counter_pkg::TAP_DIV8];
          event_counter_pkg::CKSEL_PIN:  src = pin_edge[s];
        endcase
      end
      assign pulse[s] = src & gate & split_mode_select;   // RULE_05 RULE_01
    end
  endgenerate

  // ****************************************
  // Counters
  // ****************************************
  logic [1:0] ovf;

  assign ovf[1] = pulse[1] & (event_count_high == event_counter_pkg::CNT_MAX);
  assign ovf[0] = pulse[0] & (event_count_low == event_counter_pkg::CNT_MAX);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      event_count_high <= event_counter_pkg::CNT_RESET;   // RULE_11
    end else if (pulse[1]) begin
      event_count_high <= event_count_high + 8'h01;       // RULE_06
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      event_count_low <= event_counter_pkg::CNT_RESET;    // RULE_11
    end else if (pulse[0]) begin
      event_count_low <= event_count_low + 8'h01;         // RULE_07
    end
  end

  // ****************************************
  // Flags and interrupt request
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      high_overflow_flag <= 1'b0;   // RULE_11
      low_overflow_flag  <= 1'b0;
    end else begin
      high_overflow_flag <= ovf[1] | (high_overflow_flag & ~clr_high_overflow);   // RULE_06
      low_overflow_flag  <= ovf[0] | (low_overflow_flag & ~clr_low_overflow);     // RULE_07
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      event_irq_request_flag <= 1'b0;
    end else begin
      event_irq_request_flag <= (|ovf) | (event_irq_request_flag & ~clr_irq_request);   // RULE_08
    end
  end

  assign event_irq = event_irq_request_flag & event_irq_enable;   // RULE_09

  // ****************************************
  // Checks
  // ****************************************
  sequence s_high_wrap;
    pulse[1] && event_count_high == event_counter_pkg::CNT_MAX;
  endsequence

  sequence s_low_wrap;
    pulse[0] && event_count_low == event_counter_pkg::CNT_MAX;
  endsequence

  chk_high_wrap_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_06
    s_high_wrap |=> event_count_high == 8'h00 && high_overflow_flag)
    else $error("high counter did not wrap and flag");

  chk_low_wrap_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_07
    s_low_wrap |=> event_count_low == 8'h00 && low_overflow_flag)
    else $error("low counter did not wrap and flag");

  chk_gate_holds_count: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_05
    !gate |=> $stable(event_count_high) && $stable(event_count_low))
    else $error("counter moved while gate low");

  chk_split_off_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_01
    !split_mode_select |=> $stable(event_count_high) && $stable(event_count_low))
    else $error("counter moved outside split mode");

  chk_div8_rate: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_02
    (high_clk_sel == event_counter_pkg::CKSEL_DIV8 && gate && split_mode_select && pulse[1])
    |=> !pulse[1] [*7])
    else $error("div8 pulse spacing wrong");

  chk_div2_rate: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_03
    (low_clk_sel == event_counter_pkg::CKSEL_DIV2 && pulse[0]) |=> !pulse[0])
    else $error("div2 pulse spacing wrong");

  chk_pin_rise_count: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_10
    (low_clk_sel == event_counter_pkg::CKSEL_PIN && low_edge_sel == event_counter_pkg::EDGE_RISE
     && gate && split_mode_select && $rose(sync2_ff[0]))
    |=> event_count_low == $past(event_count_low) + 8'h01)
    else $error("pin edge not counted once");

  chk_no_edge_none: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_04
    (high_clk_sel == event_counter_pkg::CKSEL_PIN && high_edge_sel == event_counter_pkg::EDGE_NONE)
    |=> $stable(event_count_high))
    else $error("counted with edge sensing off");

  chk_irq_on_ovf: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_08
    (|ovf) |=> event_irq_request_flag)
    else $error("overflow did not set request");

  chk_irq_out: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_09
    ((|ovf) && event_irq_enable) |=> event_irq || !event_irq_enable)
    else $error("interrupt not raised");

  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)   // RULE_11
    (high_overflow_flag && !clr_high_overflow) |=> high_overflow_flag)
    else $error("overflow flag dropped without clear");

endmodule

// ===== dv/event_source_model.sv
// Event pulse source driving one counter input pin
`timescale 1ns/10ps
module event_source_model #(
  parameter int HALF_NS = 16
) (
  // Control from the bench
  input  wire logic       go,
  input  wire logic [7:0] pulses,
  // Event pin
  output logic            pin
);
  // Whole pulses on each rise of go, pin idles low; one process owns the pin
  initial begin
    pin = 1'b0;
    forever begin
      @(posedge go);
      repeat (pulses) begin
        pin = 1'b1;
        #(HALF_NS);
        pin = 1'b0;
        #(HALF_NS);
      end
    end
  end
endmodule

// ===== dv/dual_8bit_event_counter_tb.sv
// Self-checking bench for the dual 8-bit event counter
`timescale 1ns/10ps
module dual_8bit_event_counter_tb;
  localparam logic [1:0] d2 = event_counter_pkg::CKSEL_DIV2, d4 = event_counter_pkg::CKSEL_DIV4;
  localparam logic [1:0] d8 = event_counter_pkg::CKSEL_DIV8, pn = event_counter_pkg::CKSEL_PIN;
  localparam logic [1:0] fa = event_counter_pkg::EDGE_FALL, ri = event_counter_pkg::EDGE_RISE;
  localparam logic [1:0] bo = event_counter_pkg::EDGE_BOTH, no = event_counter_pkg::EDGE_NONE;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, split = 1'b0, irq_en = 1'b0, go = 1'b0;
  logic        gpin = 1'b0, gpwm = 1'b0, clr_h = 1'b0, clr_l = 1'b0, clr_r = 1'b0;
  logic  [1:0] hsel = 2'h0, lsel = 2'h0, hedge = 2'h3, ledge = 2'h3;
  logic  [7:0] n = 8'h00, cnt_h, cnt_l, base_h, base_l;
  logic        pin_h, pin_l, ovf_h, ovf_l, req, irq;
  logic [34:0] rows [9];
  int          failures = 0, compares = 0;

  always #2 sys_clk = ~sys_clk;

  dual_8bit_event_counter u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .split_mode_select(split),
    .high_clk_sel(hsel), .low_clk_sel(lsel), .high_edge_sel(hedge), .low_edge_sel(ledge),
    .event_irq_enable(irq_en), .event_pin_high(pin_h), .event_pin_low(pin_l), .event_gate_pin(gpin),
    .pwm_event_gate(gpwm), .clr_high_overflow(clr_h), .clr_low_overflow(clr_l), .clr_irq_request(clr_r),
    .event_count_high(cnt_h), .event_count_low(cnt_l), .high_overflow_flag(ovf_h),
    .low_overflow_flag(ovf_l), .event_irq_request_flag(req), .event_irq(irq));
  event_source_model #(.HALF_NS(16)) u_src_h (.go(go), .pulses(n), .pin(pin_h));
  event_source_model #(.HALF_NS(24)) u_src_l (.go(go), .pulses(n), .pin(pin_l));

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp=%h got=%h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp=%b got=%b", name, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_zero;
    chk8("rst_high", 8'h00, cnt_h);
    chk8("rst_low", 8'h00, cnt_l);
    chk1("rst_flags", 1'b0, ovf_h | ovf_l | req | irq);
  endtask

  task automatic clear_flags;
    {clr_h, clr_l, clr_r} = 3'b111;
    @(negedge sys_clk);
    {clr_h, clr_l, clr_r} = 3'b000;
  endtask

  // Run one counter to wrap; the other counter sits idle
  task automatic ovf(input logic hi);
    @(negedge sys_clk);
    {split, gpin, gpwm, irq_en, hedge, ledge} = {3'b110, hi, no, no};
    hsel = hi ? d2 : pn;
    lsel = hi ? pn : d2;
    clear_flags();
    repeat (600) if ((hi ? cnt_h : cnt_l) !== 8'hFF) @(negedge sys_clk);
    repeat (3) if ((hi ? cnt_h : cnt_l) === 8'hFF) @(negedge sys_clk);
    chk8("wrap", 8'h00, hi ? cnt_h : cnt_l);
    chk1("ovf_set", 1'b1, hi ? ovf_h : ovf_l);
    chk1("ovf_other", 1'b0, hi ? ovf_l : ovf_h);
    chk1("req_set", 1'b1, req);
    chk1("irq_out", hi, irq);
    repeat (20) @(negedge sys_clk);
    chk1("ovf_sticky", 1'b1, hi ? ovf_h : ovf_l);
    clear_flags();
    chk1("ovf_clear", 1'b0, hi ? ovf_h : ovf_l);
    chk1("req_clear", 1'b0, req | irq);
  endtask

  initial begin
    #100000;
    failures++;
    end_of_test();
  end

  initial begin
    // Split, gate pin, pwm gate, selects, edges, pulses, expected deltas in 96 cycles
    rows[0] = {3'b110, d2, d4, no, no, 8'h00, 8'h30, 8'h18};
    rows[1] = {3'b110, d8, d2, no, no, 8'h00, 8'h0C, 8'h30};
    rows[2] = {3'b110, d4, d8, no, no, 8'h00, 8'h18, 8'h0C};
    rows[3] = {3'b110, pn, pn, ri, fa, 8'h05, 8'h05, 8'h05};
    rows[4] = {3'b110, pn, pn, bo, no, 8'h05, 8'h0A, 8'h00};
    rows[5] = {3'b101, d2, pn, no, bo, 8'h03, 8'h30, 8'h06};
    rows[6] = {3'b100, d2, pn, no, bo, 8'h03, 8'h00, 8'h00};
    rows[7] = {3'b010, d2, d2, no, no, 8'h00, 8'h00, 8'h00};
    rows[8] = {3'b110, pn, pn, fa, ri, 8'h04, 8'h04, 8'h04};
    repeat (12) @(negedge sys_clk);
    chk_zero();
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      // Gate off between rows so a source change never follows a tick closely
      {gpin, gpwm} = 2'b00;
      repeat (8) @(negedge sys_clk);
      @(negedge sys_clk);
      go = 1'b0;
      {split, gpin, gpwm, hsel, lsel, hedge, ledge, n} = rows[i][34:16];
      repeat (8) @(negedge sys_clk);
      base_h = cnt_h;
      base_l = cnt_l;
      go = 1'b1;
      repeat (96) @(negedge sys_clk);
      chk8("delta_high", rows[i][15:8], cnt_h - base_h);
      chk8("delta_low", rows[i][7:0], cnt_l - base_l);
    end
    ovf(1'b1);
    ovf(1'b0);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    chk_zero();
    sys_rst = 1'b0;
    end_of_test();
  end
endmodule
